/* dpa_pkg.sv */
// shared constants for the dual-port ram port controller
package dpa_pkg;

   // controller clock rate, 50 ns period
   localparam int CLK_MHZ = 20;

   // pin and word widths of one port, and the timer width
   localparam int ADDR_W = 15;
   localparam int DATA_W = 16;
   localparam int TIMER_W = 8;

   // timing figures in ns
   localparam int SETTLE_NS = 20;        // flag_delay_from_match / flag_delay_from_select, max
   localparam int ACCESS_NS = 20;        // read access after the later enable, max
   localparam int WRITE_PULSE_NS = 20;   // low time of the write strobe, min
   localparam int RECOVERY_NS = 10;      // semaphore_recovery_time, min
   localparam int FLOWTHROUGH_NS = 30;   // flowthrough_delay seen by the far port, min

   // figures in clock cycles, least times rounded up, never below one cycle
   localparam logic [TIMER_W-1:0] SETTLE_CYC =
      TIMER_W'(((SETTLE_NS * CLK_MHZ + 999) / 1000) < 1 ? 1 : ((SETTLE_NS * CLK_MHZ + 999) / 1000));
   localparam logic [TIMER_W-1:0] ACCESS_CYC =
      TIMER_W'(((ACCESS_NS * CLK_MHZ + 999) / 1000) < 1 ? 1 : ((ACCESS_NS * CLK_MHZ + 999) / 1000));
   localparam logic [TIMER_W-1:0] PULSE_CYC =
      TIMER_W'(((WRITE_PULSE_NS * CLK_MHZ + 999) / 1000) < 1 ? 1
               : ((WRITE_PULSE_NS * CLK_MHZ + 999) / 1000));
   localparam logic [TIMER_W-1:0] RECOVERY_CYC =
      TIMER_W'(((RECOVERY_NS * CLK_MHZ + 999) / 1000) < 1 ? 1
               : ((RECOVERY_NS * CLK_MHZ + 999) / 1000));
   localparam logic [TIMER_W-1:0] FLOW_CYC =
      TIMER_W'(((FLOWTHROUGH_NS * CLK_MHZ + 999) / 1000) < 1 ? 1
               : ((FLOWTHROUGH_NS * CLK_MHZ + 999) / 1000));
   // after a write the longer of the two waits applies
   localparam logic [TIMER_W-1:0] AFTER_WRITE_CYC =
      (FLOW_CYC > RECOVERY_CYC) ? FLOW_CYC : RECOVERY_CYC;

   // semaphore latch number sits in the three low address bits
   localparam int SEM_SEL_W = 3;
   // data bit carrying the semaphore value
   localparam int SEM_BIT = 0;

   // controller states
   typedef enum logic [2:0] {
      DPA_IDLE,
      DPA_WAIT_READ,
      DPA_SETTLE,
      DPA_PULSE,
      DPA_RECOVER
   } dpa_state_t;

endpackage

/* dpa_timer.sv */
`timescale 1ns/10ps
// down counter used for every timed phase of a port access
module dpa_timer #(
   parameter int WIDTH = dpa_pkg::TIMER_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   output logic expired
);
   import dpa_pkg::*;

   // whole state of the timer
   typedef struct packed {
      logic [WIDTH-1:0] count;
   } dpa_timer_t;

   dpa_timer_t cur;
   dpa_timer_t next_cur;

   // load wins over counting; holds at zero
   always_comb begin
      next_cur = cur;
      if (load) begin
         next_cur.count = load_value;
      end else if (cur.count != '0) begin
         next_cur.count = cur.count - WIDTH'(1);
      end
   end

   // single register stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // zero means the loaded number of edges has passed
   assign expired = (cur.count == '0);
endmodule

/* dpa_port_ctrl.sv */
`timescale 1ns/10ps
module dpa_port_ctrl #(
   parameter int AW = dpa_pkg::ADDR_W,
   parameter int DW = dpa_pkg::DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   // user command side
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic cmd_sem,
   input wire logic [AW-1:0] cmd_addr,
   input wire logic [DW-1:0] cmd_wdata,
   input wire logic cmd_upper,
   input wire logic cmd_lower,
   output logic cmd_ready,
   output logic rsp_done,
   output logic [DW-1:0] rsp_rdata,
   output logic rsp_sem_granted,
   // device pins of one port
   output logic [AW-1:0] ram_addr,
   output logic port_select_n,
   output logic read_write_n,
   output logic output_enable_n,
   output logic semaphore_select_n,
   output logic upper_lane_n,
   output logic lower_lane_n,
   output logic [DW-1:0] data_out,
   output logic data_oe,
   input wire logic [DW-1:0] data_in,
   input wire logic busy_n
);
   import dpa_pkg::*;

   // whole controller state; every output pin is one of these fields
   typedef struct packed {
      dpa_state_t st;          // sequencer state
      logic is_write;          // latched command kind
      logic is_sem;            // semaphore rather than array
      logic [AW-1:0] addr;     // address pins
      logic sel_n;             // array port select
      logic rw_n;              // read/write strobe
      logic oe_n;              // output drive enable
      logic sem_n;             // semaphore select
      logic ub_n;              // upper lane select
      logic lb_n;              // lower lane select
      logic [DW-1:0] dout;     // write data pins
      logic doe;               // write data drive
      logic ready;             // accepting a command
      logic done;              // one-cycle completion
      logic [DW-1:0] rdata;    // captured read word
      logic granted;           // semaphore read showed zero
   } dpa_ctrl_t;

   dpa_ctrl_t cur;
   dpa_ctrl_t next_cur;

   // timer handshake
   logic tmr_load;
   logic [TIMER_W-1:0] tmr_value;
   logic tmr_done;

   // one timer shared by all phases, they never overlap
   dpa_timer #(
      .WIDTH(TIMER_W)
   ) u_timer (
      .clk(clk),
      .rst(rst),
      .load(tmr_load),
      .load_value(tmr_value),
      .expired(tmr_done)
   );

   // next-state logic of the access sequencer
   always_comb begin
      next_cur = cur;
      tmr_load = 1'b0;
      tmr_value = '0;
      next_cur.done = 1'b0;
      case (cur.st)
         // take a command and open the access
         DPA_IDLE: begin
            if (cmd_valid) begin
               next_cur.ready = 1'b0;
               next_cur.is_write = cmd_write;
               next_cur.is_sem = cmd_sem;
               next_cur.addr = cmd_addr;
               next_cur.rw_n = 1'b1;
               if (cmd_sem) begin
                  // port select stays high, lanes stay high
                  next_cur.sem_n = 1'b0;
                  next_cur.sel_n = 1'b1;
                  next_cur.ub_n = 1'b1;
                  next_cur.lb_n = 1'b1;
                  // only bit zero matters; rest driven as one
                  next_cur.dout = {DW{1'b1}};
                  next_cur.dout[SEM_BIT] = cmd_wdata[SEM_BIT];
               end else begin
                  next_cur.sel_n = 1'b0;
                  next_cur.ub_n = ~cmd_upper;
                  next_cur.lb_n = ~cmd_lower;
                  next_cur.dout = cmd_wdata;
               end
               tmr_load = 1'b1;
               if (cmd_write) begin
                  // writes first let the busy flag settle
                  next_cur.oe_n = 1'b1;
                  tmr_value = SETTLE_CYC;
                  next_cur.st = DPA_SETTLE;
               end else begin
                  // read: select and enable together
                  next_cur.oe_n = 1'b0;
                  tmr_value = ACCESS_CYC;
                  next_cur.st = DPA_WAIT_READ;
               end
            end
         end
         // hold select and enable for the access time, then sample
         DPA_WAIT_READ: begin
            if (tmr_done) begin
               next_cur.rdata = data_in;
               next_cur.granted = ~data_in[SEM_BIT];
               next_cur.sel_n = 1'b1;
               next_cur.sem_n = 1'b1;
               next_cur.oe_n = 1'b1;
               next_cur.ub_n = 1'b1;
               next_cur.lb_n = 1'b1;
               tmr_load = 1'b1;
               tmr_value = RECOVERY_CYC;
               next_cur.st = DPA_RECOVER;
            end
         end
         // no strobe while the arbiter may still flip busy; wait out contention
         DPA_SETTLE: begin
            if (tmr_done && (busy_n || cur.is_sem)) begin
               // strobe low inside the select window
               next_cur.rw_n = 1'b0;
               next_cur.doe = 1'b1;
               tmr_load = 1'b1;
               tmr_value = PULSE_CYC;
               next_cur.st = DPA_PULSE;
            end
         end
         // end of write: strobe, select and data release on one edge
         DPA_PULSE: begin
            if (tmr_done) begin
               next_cur.rw_n = 1'b1;
               next_cur.doe = 1'b0;
               next_cur.sel_n = 1'b1;
               next_cur.sem_n = 1'b1;
               next_cur.ub_n = 1'b1;
               next_cur.lb_n = 1'b1;
               tmr_load = 1'b1;
               // covers both recovery and far-port flowthrough
               tmr_value = AFTER_WRITE_CYC;
               next_cur.st = DPA_RECOVER;
            end
         end
         // all pins idle; next access cannot start before this ends
         DPA_RECOVER: begin
            if (tmr_done) begin
               next_cur.done = 1'b1;
               next_cur.ready = 1'b1;
               next_cur.st = DPA_IDLE;
            end
         end
         default: begin
            next_cur.st = DPA_IDLE;
            next_cur.ready = 1'b1;
         end
      endcase
   end

   // single register of the whole state; pins rest deselected
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cur <= '0;
         cur.st <= DPA_IDLE;
         cur.sel_n <= 1'b1;
         cur.rw_n <= 1'b1;
         cur.oe_n <= 1'b1;
         cur.sem_n <= 1'b1;
         cur.ub_n <= 1'b1;
         cur.lb_n <= 1'b1;
         cur.ready <= 1'b1;
      end else begin
         cur <= next_cur;
      end
   end

   // outputs straight from the state register
   assign cmd_ready = cur.ready;
   assign rsp_done = cur.done;
   assign rsp_rdata = cur.rdata;
   assign rsp_sem_granted = cur.granted;
   assign ram_addr = cur.addr;
   assign port_select_n = cur.sel_n;
   assign read_write_n = cur.rw_n;
   assign output_enable_n = cur.oe_n;
   assign semaphore_select_n = cur.sem_n;
   assign upper_lane_n = cur.ub_n;
   assign lower_lane_n = cur.lb_n;
   assign data_out = cur.dout;
   assign data_oe = cur.doe;

   // write strobe only inside an active select
   sequence write_strobe_s;
      !read_write_n;
   endsequence
   write_overlap_a: assert property (@(posedge clk) disable iff (rst)
      write_strobe_s |-> (!port_select_n || !semaphore_select_n) && data_oe && output_enable_n
         && cur.is_write)
      else $error("write strobe outside select or without data drive");

   // after a write nothing is reported before the flowthrough wait
   write_done_gap_a: assert property (@(posedge clk) disable iff (rst)
      $rose(read_write_n) |-> (!rsp_done)[*2])
      else $error("write reported before flowthrough delay");

   // output enable low only with a select active and the write strobe high
   read_enable_a: assert property (@(posedge clk) disable iff (rst)
      !output_enable_n |-> read_write_n && (!port_select_n || !semaphore_select_n))
      else $error("output enable without a select or during write");

   // a semaphore read keeps enable low with lanes high
   sem_read_pins_a: assert property (@(posedge clk) disable iff (rst)
      (!semaphore_select_n && read_write_n && cur.st == DPA_WAIT_READ)
      |-> !output_enable_n && upper_lane_n && lower_lane_n)
      else $error("semaphore read pins wrong");

   // a write strobe follows a settled busy flag
   busy_settle_a: assert property (@(posedge clk) disable iff (rst)
      $fell(read_write_n) && !port_select_n |-> $past(busy_n) && $past(port_select_n, 2) == 1'b0)
      else $error("write started before busy settled");

   // port select never low together with semaphore select
   sem_select_excl_a: assert property (@(posedge clk) disable iff (rst)
      !semaphore_select_n |-> port_select_n)
      else $error("port select low during semaphore access");

   // semaphore select rests high across the recovery gap after a write
   sequence sem_release_s;
      $rose(semaphore_select_n) && !$past(read_write_n);
   endsequence
   sem_recovery_a: assert property (@(posedge clk) disable iff (rst)
      sem_release_s |-> semaphore_select_n[*2])
      else $error("semaphore reselected inside recovery time");

   // semaphore write data carries the value in bit zero only
   sem_data_a: assert property (@(posedge clk) disable iff (rst)
      (data_oe && !semaphore_select_n) |-> data_out[DW-1:1] == {(DW-1){1'b1}})
      else $error("semaphore write data not confined to bit zero");
endmodule

/* dpa_dev_model.sv */
`timescale 1ns/10ps
// behavioural device: left port pins come from the controller, right port is worked by tasks
module dpa_dev_model
   import dpa_pkg::*;
(
   input wire logic [ADDR_W-1:0] l_addr,
   input wire logic l_sel_n,
   input wire logic l_rw_n,
   input wire logic l_oe_n,
   input wire logic l_sem_n,
   input wire logic l_ub_n,
   input wire logic l_lb_n,
   input wire logic [DATA_W-1:0] l_wd,
   input wire logic l_doe,
   output logic [DATA_W-1:0] l_rd,
   output logic busy_l_n // master role: busy driven out
);
   logic [DATA_W-1:0] mem [0:(1 << ADDR_W) - 1]; // whole array, cleared at start
   logic [1:0] owner [8]; // 0 free, 1 left, 2 right
   logic [1:0] pend [8]; // bit0 left waits, bit1 right waits
   logic int_l_n = 1'b1; // mailbox flags, active low
   logic int_r_n = 1'b1;
   logic [ADDR_W-1:0] r_addr = '0; // right port address and select
   logic r_sel_n = 1'b1;
   logic r_first = 1'b0; // right selected before left
   logic [DATA_W-1:0] last = '0; // last word driven, for released bus
   localparam logic [ADDR_W-1:0] MBOX_R = '1;
   localparam logic [ADDR_W-1:0] MBOX_L = MBOX_R - 1'b1;

   // all latches free at start
   initial begin
      l_rd = '1;
      foreach (mem[i]) mem[i] = '0;
      foreach (owner[i]) begin
         owner[i] = 2'd0;
         pend[i] = 2'd0;
      end
   end

   // loser is the later port on a matching address
   assign busy_l_n = !(!l_sel_n && !r_sel_n && l_addr == r_addr && r_first);

   // only bit zero counts; zero requests, one releases or cancels
   task automatic sem_wr(input int p, input logic [2:0] k, input logic b);
      if (!b) begin
         if (owner[k] == 2'd0) owner[k] = 2'(p);
         else if (owner[k] != 2'(p)) pend[k][p-1] = 1'b1;
      end else if (owner[k] == 2'(p)) begin
         owner[k] = pend[k][2-p] ? 2'(3 - p) : 2'd0;
         pend[k][2-p] = 1'b0;
      end else pend[k][p-1] = 1'b0;
   endtask

   // owner reads zero, everyone else one
   function automatic logic sem_rd(input int p, input logic [2:0] k);
      return owner[k] != 2'(p);
   endfunction

   // stored at once, so flowthrough is met by any later read
   task automatic arr_wr(input int p, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input logic [1:0] ln);
      logic [DATA_W-1:0] old;
      old = mem[a];
      mem[a] = {ln[1] ? d[15:8] : old[15:8], ln[0] ? d[7:0] : old[7:0]};
      if (p == 1 && a == MBOX_R && busy_l_n) int_r_n = 1'b0;
      if (p == 2 && a == MBOX_L) int_l_n = 1'b0;
   endtask

   // left write lands where select and write strobe first overlap
   always @(negedge l_rw_n or negedge l_sel_n or negedge l_sem_n) begin
      #1;
      if (!l_rw_n && l_doe && !l_sem_n) sem_wr(1, l_addr[2:0], l_wd[SEM_BIT]);
      else if (!l_rw_n && l_doe && !l_sel_n && busy_l_n) // loser writes nothing
         arr_wr(1, l_addr, l_wd, {!l_ub_n, !l_lb_n});
   end

   // read value captured when the drive turns on, then held
   always @(negedge l_oe_n or negedge l_sel_n or negedge l_sem_n) begin
      #1;
      if (!l_oe_n && l_rw_n && !l_sem_n) l_rd = {DATA_W{sem_rd(1, l_addr[2:0])}};
      else if (!l_oe_n && l_rw_n && !l_sel_n) begin
         l_rd = mem[l_addr];
         if (l_ub_n) l_rd[15:8] = ~last[15:8]; // lane not driven
         if (l_lb_n) l_rd[7:0] = ~last[7:0];
         if (l_addr == MBOX_L && busy_l_n) int_l_n = 1'b1;
      end
      last = l_rd;
   end

   // a released bus must not keep showing the old word
   always @(posedge l_oe_n) l_rd = ~last;

   // right port accesses, instantaneous
   task automatic right_hold(input logic [ADDR_W-1:0] a);
      r_first = l_sel_n;
      r_addr = a;
      r_sel_n = 1'b0;
   endtask
   task automatic right_free();
      r_sel_n = 1'b1;
   endtask
   task automatic right_wr(input logic s, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      if (s) sem_wr(2, a[2:0], d[SEM_BIT]);
      else arr_wr(2, a, d, 2'b11);
   endtask
   task automatic right_rd(input logic s, input logic [ADDR_W-1:0] a,
                           output logic [DATA_W-1:0] d);
      if (s) d = {DATA_W{sem_rd(2, a[2:0])}};
      else begin
         d = mem[a];
         if (a == MBOX_R) int_r_n = 1'b1;
      end
   endtask
endmodule

/* tb_dual_port_ram_arbitration.sv */
`timescale 1ns/10ps
// bench: controller drives the left port, right port is worked through model tasks
module tb_dual_port_ram_arbitration;
   import dpa_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_sem = 1'b0, cmd_upper = 1'b0, cmd_lower = 1'b0;
   logic [ADDR_W-1:0] cmd_addr = '0, ram_addr;
   logic [DATA_W-1:0] cmd_wdata = '0, rsp_rdata, data_out, data_in;
   logic cmd_ready, rsp_done, rsp_sem_granted, data_oe, busy_n;
   logic port_select_n, read_write_n, output_enable_n, semaphore_select_n;
   logic upper_lane_n, lower_lane_n;
   int err_count = 0;
   int checks_done = 0;

   dpa_port_ctrl dut (.clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_sem(cmd_sem), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_upper(cmd_upper),
      .cmd_lower(cmd_lower), .cmd_ready(cmd_ready), .rsp_done(rsp_done),
      .rsp_rdata(rsp_rdata), .rsp_sem_granted(rsp_sem_granted), .ram_addr(ram_addr),
      .port_select_n(port_select_n), .read_write_n(read_write_n),
      .output_enable_n(output_enable_n), .semaphore_select_n(semaphore_select_n),
      .upper_lane_n(upper_lane_n), .lower_lane_n(lower_lane_n), .data_out(data_out),
      .data_oe(data_oe), .data_in(data_in), .busy_n(busy_n));

   dpa_dev_model model (.l_addr(ram_addr), .l_sel_n(port_select_n), .l_rw_n(read_write_n),
      .l_oe_n(output_enable_n), .l_sem_n(semaphore_select_n), .l_ub_n(upper_lane_n),
      .l_lb_n(lower_lane_n), .l_wd(data_out), .l_doe(data_oe), .l_rd(data_in),
      .busy_l_n(busy_n));

   // 20 MHz clock
   initial begin
      forever #25 clk = ~clk;
   end

   task automatic chk(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // present one command for one edge; taken while ready is high
   task automatic start_op(input logic w, input logic s, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] d, input logic [1:0] ln);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_sem <= s;
      cmd_addr <= a;
      cmd_wdata <= d;
      {cmd_upper, cmd_lower} <= ln;
      @(posedge clk);
      cmd_valid <= 1'b0;
   endtask

   // bounded wait for the one-cycle done pulse
   task automatic wait_done();
      int n;
      n = 0;
      while (rsp_done !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 40) chk("done pulse", 16'h0001, {15'h0, rsp_done});
   endtask

   task automatic op(input logic w, input logic s, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [1:0] ln);
      start_op(w, s, a, d, ln);
      wait_done();
   endtask

   task automatic t_reset();
      chk("idle pins", 16'h003f, {10'h0, port_select_n, read_write_n, output_enable_n,
          semaphore_select_n, upper_lane_n, lower_lane_n});
      chk("idle ready", 16'h0001, {15'h0, cmd_ready});
   endtask

   // lane writes merge, lane reads return only their byte
   task automatic t_array();
      op(1'b1, 1'b0, 15'h0005, 16'h1234, 2'b11);
      op(1'b1, 1'b0, 15'h0005, 16'habcd, 2'b10);
      op(1'b0, 1'b0, 15'h0005, 16'h0000, 2'b11);
      chk("merged word", 16'hab34, rsp_rdata);
      op(1'b0, 1'b0, 15'h0005, 16'h0000, 2'b01);
      chk("low lane", 16'h0034, {8'h00, rsp_rdata[7:0]});
   endtask

   task automatic t_mailbox();
      logic [DATA_W-1:0] v;
      op(1'b1, 1'b0, 15'h7fff, 16'h00c1, 2'b11);
      chk("right flag set", 16'h0000, {15'h0, model.int_r_n});
      model.right_wr(1'b0, 15'h7ffe, 16'h00d2);
      chk("left flag set", 16'h0000, {15'h0, model.int_l_n});
      op(1'b0, 1'b0, 15'h7fff, 16'h0000, 2'b11);
      chk("far mailbox", 16'h00c1, rsp_rdata);
      chk("far flag kept", 16'h0000, {15'h0, model.int_r_n});
      op(1'b0, 1'b0, 15'h7ffe, 16'h0000, 2'b11);
      chk("own mailbox", 16'h00d2, rsp_rdata);
      chk("left flag clear", 16'h0001, {15'h0, model.int_l_n});
      model.right_rd(1'b0, 15'h7fff, v);
   endtask

   // every latch, with noise in the ignored address bits
   task automatic t_sem();
      logic [DATA_W-1:0] v;
      logic [ADDR_W-1:0] a;
      for (int k = 0; k < 8; k++) begin
         a = {12'(k * 37 + 1), 3'(k)};
         op(1'b0, 1'b1, a, 16'h0000, 2'b00);
         chk("free latch", 16'hffff, rsp_rdata);
         op(1'b1, 1'b1, a, 16'hfffe, 2'b00);
         op(1'b0, 1'b1, a, 16'h0000, 2'b00);
         chk("own token", 16'h0000, rsp_rdata);
         chk("granted", 16'h0001, {15'h0, rsp_sem_granted});
         model.right_rd(1'b1, a, v);
         chk("far view", 16'hffff, v);
         model.right_wr(1'b1, a, 16'h0000);
         op(1'b1, 1'b1, a, 16'h0001, 2'b00);
         op(1'b0, 1'b1, a, 16'h0000, 2'b00);
         chk("after release", 16'hffff, rsp_rdata);
         model.right_rd(1'b1, a, v);
         chk("handover", 16'h0000, v);
         model.right_wr(1'b1, a, 16'h0001);
      end
   endtask

   // write to a location the right port already holds must wait
   task automatic t_busy();
      model.right_hold(15'h0009);
      op(1'b1, 1'b0, 15'h000a, 16'h5151, 2'b11);
      start_op(1'b1, 1'b0, 15'h0009, 16'h7777, 2'b11);
      repeat (10) begin
         @(posedge clk);
         #1;
         chk("write held", 16'h0000, {13'h0, cmd_ready, rsp_done, ~read_write_n});
      end
      chk("busy seen", 16'h0000, {15'h0, busy_n});
      model.right_free();
      wait_done();
      op(1'b0, 1'b0, 15'h0009, 16'h0000, 2'b11);
      chk("late write", 16'h7777, rsp_rdata);
   endtask

   task automatic finish_test();
      if (err_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // about fifty accesses of under twenty cycles each
   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      finish_test();
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      t_reset();
      t_array();
      t_mailbox();
      t_sem();
      t_busy();
      finish_test();
   end
endmodule
